// ---- qei_pkg.sv ----
// Constants, register layouts and field types of the encoder interface.
// Assumes one 40 MHz clock and a 32-bit AXI4-Lite register port.
package qei_pkg;

	// --------------------------------------------------------------
	// Register indices and byte addresses
	// --------------------------------------------------------------
	localparam int          ADDR_W      = 12;
	localparam logic [11:0] CTRL_IDX    = 12'h122;
	localparam logic [11:0] FILT_IDX    = 12'h124;
	localparam logic [11:0] POS_IDX     = 12'h126;
	localparam logic [11:0] MAX_IDX     = 12'h128;
	localparam logic [11:0] STAT_IDX    = 12'h12a;
	localparam logic [11:0] CTRL_ADDR   = {CTRL_IDX[9:0], 2'b00};
	localparam logic [11:0] FILT_ADDR   = {FILT_IDX[9:0], 2'b00};
	localparam logic [11:0] POS_ADDR    = {POS_IDX[9:0], 2'b00};
	localparam logic [11:0] MAX_ADDR    = {MAX_IDX[9:0], 2'b00};
	localparam logic [11:0] STAT_ADDR   = {STAT_IDX[9:0], 2'b00};

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [15:0] CTRL_RST    = 16'h0000;
	localparam logic [15:0] FILT_RST    = 16'h0000;
	localparam logic [15:0] POS_RST     = 16'h0000;
	localparam logic [15:0] MAX_RST     = 16'hffff;
	localparam logic [15:0] ERR_DOWN_V  = 16'hffff;

	// Writable bits; index level and bit 14 are read-only
	localparam logic [15:0] CTRL_WMASK  = 16'hafff;
	localparam logic [15:0] FILT_WMASK  = 16'h01f0;
	localparam int          STAT_IRQ_B  = 0;

	// --------------------------------------------------------------
	// Modes and timing counts
	// --------------------------------------------------------------
	localparam logic [2:0]  MODE_OFF    = 3'h0;
	localparam logic [2:0]  MODE_TIMER  = 3'h1;
	localparam logic [2:0]  MODE_X2_IDX = 3'h4;
	localparam logic [2:0]  MODE_X2_MAX = 3'h5;
	localparam logic [2:0]  MODE_X4_IDX = 3'h6;
	localparam logic [2:0]  MODE_X4_MAX = 3'h7;
	localparam logic [1:0]  FILT_STABLE = 2'h3;
	localparam logic [7:0]  PS_DIV1     = 8'h00;
	localparam logic [7:0]  PS_DIV8     = 8'h07;
	localparam logic [7:0]  PS_DIV64    = 8'h3f;
	localparam logic [7:0]  PS_DIV256   = 8'hff;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// --------------------------------------------------------------
	// Field layouts
	// --------------------------------------------------------------
	typedef struct packed {
		logic       count_error_flag;
		logic       rsv14;
		logic       idle_stop;
		logic       index_level;
		logic       count_direction;
		logic [2:0] mode_select;
		logic       swap_phases;
		logic       direction_pin_output_enable;
		logic       timer_gate_en;
		logic [1:0] timer_prescale;
		logic       index_reset_enable;
		logic       timer_clk_ext;
		logic       direction_source_select;
	} qei_ctrl_t;

	typedef struct packed {
		logic [6:0] rsv_hi;
		logic       count_error_irq_disable;
		logic       filter_output_enable;
		logic [2:0] filter_clock_divider;
		logic [3:0] rsv_lo;
	} qei_filt_t;

	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic index;
	} qei_pins_t;

endpackage

// ---- qei_encoder.sv ----
// Quadrature encoder interface with AXI4-Lite registers and timer mode.
// Assumes encoder pins are asynchronous; cpu_idle is on the aclk domain.

// Contract
// - A leading B means forward, A lagging B means reverse.
// - Mode comes from three-bit mode_select, control bits 10 down to 8.
// - Modes 100/101 count both edges of A only; B sets direction.
// - Modes 110/111 count every edge of both A and B.
// - Modes 101/111 reset count on max match; 100/110 on index.
// - Index resets count only when index_reset_enable is set.
// - Index still interrupts when reset disabled; max and timer rollover do too.
// - Index modes flag count error at 0xffff or max plus one.
// - count_error_irq_disable suppresses the count error interrupt.
// - After an error counting continues; natural wrap interrupts only as a count error at 0xffff or max plus one.
// - count_error_flag is software read/write and sticky until cleared.
// - Decoded direction is readable as count_direction, control bit 11.
// - Direction pin driven only while its output enable bit is set.
// - Filter output changes only after three stable filter clocks.
// - Filter clock divided from aclk by filter_clock_divider.
// - Filtered inputs used only when enabled; filters off after reset.
// - Timer uses position as count, max as period; match sets flag.
// - Timer count clock comes from the phase A pin when timer_clk_ext is set, else aclk.
// - Timer direction from count_direction, or phase B when selected.
// - Mode changes leave the shared count register unchanged.
// - External count clock is always synchronised to aclk.
// - While idle, halt if idle_stop is set; bit resets to zero.
// - One sticky encoder_irq_flag for all events until software clears.
module qei_encoder
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [qei_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [qei_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire qei_pkg::qei_pins_t        enc_pins,
	input  wire logic                      cpu_idle,
	output logic                           dir_pin_out,
	output logic                           dir_pin_oe,
	output logic                           encoder_irq_flag
);
	import qei_pkg::*;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	qei_ctrl_t   ctrl_reg;
	qei_filt_t   filt_reg;
	logic [15:0] pos_reg;
	logic [15:0] max_reg;
	logic        irq_reg;
	logic        dir_reg;

	// --------------------------------------------------------------
	// AXI4-Lite write path
	// --------------------------------------------------------------
	logic              aw_hold_reg;
	logic              w_hold_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;

	wire        do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	wire [15:0] wmask    = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire [15:0] wval     = w_data_reg[15:0];
	wire        wr_ctrl  = do_write & (aw_addr_reg == CTRL_ADDR);
	wire        wr_filt  = do_write & (aw_addr_reg == FILT_ADDR);
	wire        wr_pos   = do_write & (aw_addr_reg == POS_ADDR);
	wire        wr_max   = do_write & (aw_addr_reg == MAX_ADDR);
	wire        wr_stat  = do_write & (aw_addr_reg == STAT_ADDR);
	wire        wr_hit   = wr_ctrl | wr_filt | wr_pos | wr_max | wr_stat;

	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg & s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Input synchronisers and noise filters
	// --------------------------------------------------------------
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] filt_q;
	logic [7:0] fdiv_reg;
	wire  [7:0] fdiv_top = 8'((9'h1 << filt_reg.filter_clock_divider) - 9'h1);
	wire        ftick    = (fdiv_reg == fdiv_top);

	// Pins only reach logic through two flops
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			fdiv_reg  <= 8'h00;
		end
		else
		begin
			sync1_reg <= enc_pins;
			sync2_reg <= sync1_reg;
			fdiv_reg  <= ftick ? 8'h00 : fdiv_reg + 8'h01;
		end
	end

	for (genvar i = 0; i < 3; i++)
	begin : g_filt
		logic [1:0] cnt_reg;
		logic       out_reg;
		wire  [1:0] cnt_inc = cnt_reg + 2'h1;

		assign filt_q[i] = out_reg;
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				cnt_reg <= 2'h0;
				out_reg <= 1'b0;
			end
			else if (ftick)
			begin
				if (sync2_reg[i] == out_reg)
					cnt_reg <= 2'h0;
				else if (cnt_inc == FILT_STABLE)
				begin
					out_reg <= sync2_reg[i];
					cnt_reg <= 2'h0;
				end
				else
					cnt_reg <= cnt_inc;
			end
		end
	end

	// Filtered copy only when enabled, which reset clears
	wire [2:0] in_sel = filt_reg.filter_output_enable ? filt_q : sync2_reg;
	wire       a_s    = ctrl_reg.swap_phases ? in_sel[1] : in_sel[2];
	wire       b_s    = ctrl_reg.swap_phases ? in_sel[2] : in_sel[1];
	wire       i_s    = in_sel[0];

	// --------------------------------------------------------------
	// Quadrature decode
	// --------------------------------------------------------------
	logic a_d_reg;
	logic b_d_reg;
	logic i_d_reg;
	logic ta_d_reg;
	logic [7:0] ps_reg;

	wire [2:0] mode      = ctrl_reg.mode_select;
	wire       run       = ~(cpu_idle & ctrl_reg.idle_stop);
	wire       enc_mode  = mode[2];
	wire       max_mode  = mode[0];
	wire       tmr_mode  = (mode == MODE_TIMER);
	wire       a_edge    = a_s ^ a_d_reg;
	wire       b_edge    = b_s ^ b_d_reg;
	// A leads B: on an A edge phases differ, on a B edge they match
	wire       dir_now   = a_edge ? (a_s ^ b_s) : ~(a_s ^ b_s);
	wire       step      = run & enc_mode & (a_edge | (mode[1] & b_edge));
	// Index only counts as a reference while both phases are low
	wire       idx_qual  = run & enc_mode & ~max_mode & i_s & ~i_d_reg
	                       & ~a_s & ~b_s;
	wire       idx_rst   = idx_qual & ctrl_reg.index_reset_enable;

	// Timer clock: phase A pin through the synchroniser, or aclk
	wire       ta_rise   = sync2_reg[2] & ~ta_d_reg;
	wire       tsrc      = ctrl_reg.timer_clk_ext ? ta_rise : 1'b1;
	wire [7:0] ps_top    = (ctrl_reg.timer_prescale == 2'h0) ? PS_DIV1 :
	                       (ctrl_reg.timer_prescale == 2'h1) ? PS_DIV8 :
	                       (ctrl_reg.timer_prescale == 2'h2) ? PS_DIV64 :
	                       PS_DIV256;
	wire       ttick     = run & tmr_mode & tsrc & (ps_reg == ps_top);
	wire       t_up      = ctrl_reg.direction_source_select ? sync2_reg[1]
	                       : ctrl_reg.count_direction;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			a_d_reg  <= 1'b0;
			b_d_reg  <= 1'b0;
			i_d_reg  <= 1'b0;
			ta_d_reg <= 1'b0;
			ps_reg   <= 8'h00;
			dir_reg  <= 1'b0;
		end
		else
		begin
			a_d_reg  <= a_s;
			b_d_reg  <= b_s;
			i_d_reg  <= i_s;
			ta_d_reg <= sync2_reg[2];
			if (run & tmr_mode & tsrc)
				ps_reg <= (ps_reg == ps_top) ? 8'h00 : ps_reg + 8'h01;
			if (step)
				dir_reg <= dir_now;
		end
	end

	// --------------------------------------------------------------
	// Position count, events and flags
	// --------------------------------------------------------------
	wire [15:0] pos_inc  = pos_reg + 16'h1;
	wire [15:0] pos_dec  = pos_reg - 16'h1;
	wire [15:0] max_inc  = max_reg + 16'h1;
	wire        at_max   = (pos_reg == max_reg);
	wire        at_zero  = (pos_reg == 16'h0);
	wire        cnt_up   = tmr_mode ? t_up : dir_now;
	wire        cnt_step = step | ttick;
	wire        wrap_cnt = (tmr_mode | max_mode) & (cnt_up ? at_max : at_zero);
	wire        roll_evt = cnt_step & wrap_cnt;
	// Index modes wrap naturally; only a count error can interrupt on it
	wire [15:0] step_val = wrap_cnt ? (cnt_up ? 16'h0 : max_reg)
	                       : (cnt_up ? pos_inc : pos_dec);
	wire        err_evt  = step & ~max_mode & ~idx_rst &
	                       (dir_now ? (step_val == max_inc)
	                       : (step_val == ERR_DOWN_V));
	wire        irq_set  = roll_evt | idx_qual
	                       | (err_evt & ~filt_reg.count_error_irq_disable);
	wire [15:0] pos_hw   = idx_rst ? 16'h0 : (cnt_step ? step_val : pos_reg);
	wire [15:0] ctrl_w   = (ctrl_reg & ~(wmask & CTRL_WMASK))
	                       | (wval & wmask & CTRL_WMASK);
	wire        err_next = (wr_ctrl ? ctrl_w[15] : ctrl_reg.count_error_flag)
	                       | err_evt;
	wire        irq_clr  = wr_stat & w_strb_reg[0] & wval[STAT_IRQ_B];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg <= CTRL_RST;
			filt_reg <= FILT_RST;
			pos_reg  <= POS_RST;
			max_reg  <= MAX_RST;
			irq_reg  <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= ctrl_w;
			ctrl_reg.count_error_flag <= err_next;
			if (wr_filt)
				filt_reg <= (filt_reg & ~(wmask & FILT_WMASK))
				            | (wval & wmask & FILT_WMASK);
			// Software write wins over a count step; mode changes leave it
			if (wr_pos)
				pos_reg <= (pos_reg & ~wmask) | (wval & wmask);
			else
				pos_reg <= pos_hw;
			if (wr_max)
				max_reg <= (max_reg & ~wmask) | (wval & wmask);
			// An event in the clearing cycle keeps the flag set
			irq_reg <= (irq_reg & ~irq_clr) | irq_set;
		end
	end

	assign encoder_irq_flag = irq_reg;
	assign dir_pin_out      = dir_reg;
	assign dir_pin_oe       = ctrl_reg.direction_pin_output_enable;

	// --------------------------------------------------------------
	// AXI4-Lite read path
	// --------------------------------------------------------------
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;

	wire        dir_rd   = tmr_mode ? ctrl_reg.count_direction : dir_reg;
	wire [15:0] ctrl_rd  = {ctrl_reg.count_error_flag, 1'b0,
	                        ctrl_reg.idle_stop, i_s, dir_rd, ctrl_reg[10:0]};
	wire        rd_ctrl  = (s_axi_araddr == CTRL_ADDR);
	wire        rd_filt  = (s_axi_araddr == FILT_ADDR);
	wire        rd_pos   = (s_axi_araddr == POS_ADDR);
	wire        rd_max   = (s_axi_araddr == MAX_ADDR);
	wire        rd_stat  = (s_axi_araddr == STAT_ADDR);
	wire        rd_hit   = rd_ctrl | rd_filt | rd_pos | rd_max | rd_stat;
	wire [15:0] rd_val   = rd_ctrl ? ctrl_rd :
	                       rd_filt ? filt_reg :
	                       rd_pos  ? pos_reg :
	                       rd_max  ? max_reg :
	                       rd_stat ? {15'h0, irq_reg} : 16'h0;

	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= RESP_OKAY;
		end
		else if (s_axi_arvalid & ~rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {16'h0, rd_val};
			rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg & s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	a_fwd_dir: assert property (step & a_edge & a_s & ~b_s |=> dir_reg)
		else $error("forward edge did not set direction");
	a_off_hold: assert property (mode == MODE_OFF & ~wr_pos
		|=> $stable(pos_reg))
		else $error("count moved while module off");
	a_x2_b_ign: assert property (enc_mode & ~mode[1] & ~a_edge & ~idx_rst
		& ~wr_pos |=> $stable(pos_reg))
		else $error("x2 mode counted without an A edge");
	a_x4_b_step: assert property (run & mode == MODE_X4_MAX & b_edge
		& ~a_edge & dir_now & ~at_max & ~wr_pos
		|=> pos_reg == $past(pos_inc))
		else $error("x4 mode missed a B edge");
	a_max_roll: assert property (step & max_mode & dir_now & at_max
		& ~wr_pos |=> pos_reg == 16'h0 && irq_reg)
		else $error("max match did not roll over");
	a_idx_reset: assert property (idx_rst & ~wr_pos
		|=> pos_reg == 16'h0)
		else $error("index did not clear count");
	a_idx_irq: assert property (idx_qual |=> irq_reg)
		else $error("index did not raise flag");
	a_err_set: assert property (err_evt |=> ctrl_reg.count_error_flag)
		else $error("count error not flagged");
	a_count_error_irq_disable_mask: assert property (err_evt & filt_reg.count_error_irq_disable
		& ~idx_qual & ~roll_evt & ~irq_reg & ~wr_stat |=> ~irq_reg)
		else $error("disabled count error raised flag");
	a_err_sticky: assert property (ctrl_reg.count_error_flag & ~wr_ctrl
		|=> ctrl_reg.count_error_flag)
		else $error("count error flag dropped");
	a_dir_pin: assert property (step & ctrl_reg.direction_pin_output_enable
		& ~wr_ctrl |=> dir_pin_oe && dir_pin_out == $past(dir_now))
		else $error("direction pin does not follow decoded direction");
	a_filt_hold: assert property ($changed(filt_q[2])
		|-> $past(ftick) && $past(g_filt[2].cnt_reg) == 2'h2)
		else $error("filter changed before three stable clocks");
	a_tmr_period: assert property (ttick & t_up & at_max & ~wr_pos
		|=> pos_reg == 16'h0 ##0 irq_reg)
		else $error("timer period match missed");
	a_idle_halt: assert property (cpu_idle & ctrl_reg.idle_stop & ~wr_pos
		|=> $stable(pos_reg))
		else $error("count moved while halted in idle");
	a_irq_sticky: assert property (irq_reg & ~irq_clr |=> irq_reg)
		else $error("irq flag dropped without clear");

endmodule // qei_encoder

// ---- qei_enc_model.sv ----
// Incremental encoder model: two phases and an index pulse.
// Assumes the bench calls its tasks from the aclk domain.
module qei_enc_model
(
	input  wire logic          aclk,
	output qei_pkg::qei_pins_t pins
);
	import qei_pkg::*;
	int q = 0;
	initial pins = '0;
	// Gray order 00,10,11,01: A leads B when moving forward
	task automatic step(input bit fwd);
		q = fwd ? (q + 1) % 4 : (q + 3) % 4;
		@(posedge aclk);
		pins.phase_a <= (q == 1 || q == 2);
		pins.phase_b <= (q >= 2);
		repeat (6) @(posedge aclk);
	endtask
	// Pulse only while both phases sit low
	task automatic index_pulse();
		if (q == 0)
		begin
			@(posedge aclk);
			pins.index <= 1'b1;
			repeat (4) @(posedge aclk);
			pins.index <= 1'b0;
			repeat (6) @(posedge aclk);
		end
	endtask
	// Two-cycle spike on A, shorter than the filter window
	task automatic glitch();
		@(posedge aclk);
		pins.phase_a <= ~pins.phase_a;
		repeat (2) @(posedge aclk);
		pins.phase_a <= ~pins.phase_a;
		repeat (6) @(posedge aclk);
	endtask
endmodule // qei_enc_model

// ---- test_qei_encoder.sv ----
// Self-checking bench of the encoder interface over AXI4-Lite.
// Assumes qei_pkg and qei_enc_model are compiled first.
module test_qei_encoder;
	timeunit 1ns;
	timeprecision 1ps;
	import qei_pkg::*;
	logic        aclk = 0, aresetn = 0, cpu_idle = 0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rd, seed = 32'd96454;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        dpo, doe, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	qei_pins_t   pins;
	int          error_cnt = 0, cmp_count = 0, exp_pos = 0;
	always #12.5 aclk = ~aclk;
	qei_encoder qei_encoder_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .enc_pins(pins),
		.cpu_idle(cpu_idle), .dir_pin_out(dpo), .dir_pin_oe(doe),
		.encoder_irq_flag(irq));
	qei_enc_model qei_enc_model_i (.aclk(aclk), .pins(pins));
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// Both channels offered together, each dropped once taken
	task automatic wr(logic [11:0] a, logic [15:0] d, logic [1:0] e);
		bit ad = 0;
		bit dd = 0;
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			ad = ad | awready;
			dd = dd | wready;
			awvalid <= !ad;
			wvalid <= !dd;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk("bresp", bresp, e);
	endtask
	task automatic rdr(logic [11:0] a, logic [1:0] e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		chk("rresp", rresp, e);
	endtask
	task automatic steps(int n, bit fwd);
		repeat (n) qei_enc_model_i.step(fwd);
		repeat (4) @(posedge aclk);
	endtask
	task automatic chk_pos();
		rdr(POS_ADDR, RESP_OKAY);
		chk("position", rd, exp_pos & 32'hffff);
	endtask
	task automatic clr_irq();
		wr(STAT_ADDR, 16'h0001, RESP_OKAY);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#(25 * 40000);
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdr(CTRL_ADDR, RESP_OKAY);
		chk("ctrl reset", rd & 32'hefff, 32'h0);
		rdr(FILT_ADDR, RESP_OKAY);
		chk("filt reset", rd, 32'h0);
		rdr(MAX_ADDR, RESP_OKAY);
		chk("max reset", rd, 32'hffff);
		rdr(12'h004, RESP_SLVERR);
		wr(12'h004, 16'h1234, RESP_SLVERR);
		// x4 with index reset off, direction pin driven
		wr(CTRL_ADDR, 16'h0640, RESP_OKAY);
		steps(8, 1);
		exp_pos = 8;
		chk_pos();
		rdr(CTRL_ADDR, RESP_OKAY);
		chk("dir fwd", rd[11], 1'b1);
		chk("dir pin", {doe, dpo}, 2'b11);
		steps(4, 0);
		exp_pos = 4;
		chk_pos();
		rdr(CTRL_ADDR, RESP_OKAY);
		chk("dir rev", rd[11], 1'b0);
		chk("dir pin rev", {doe, dpo}, 2'b10);
		// x2 counts only edges of A
		wr(CTRL_ADDR, 16'h0400, RESP_OKAY);
		steps(4, 1);
		exp_pos = 6;
		chk_pos();
		chk("pin off", doe, 1'b0);
		clr_irq();
		wr(CTRL_ADDR, 16'h0604, RESP_OKAY);
		qei_enc_model_i.index_pulse();
		exp_pos = 0;
		chk_pos();
		chk("index irq", irq, 1'b1);
		clr_irq();
		wr(CTRL_ADDR, 16'h0600, RESP_OKAY);
		steps(4, 1);
		qei_enc_model_i.index_pulse();
		exp_pos = 4;
		chk_pos();
		chk("index irq kept", irq, 1'b1);
		// Landing on max plus one flags a count error
		clr_irq();
		wr(MAX_ADDR, 16'h0005, RESP_OKAY);
		steps(2, 1);
		exp_pos = 6;
		rdr(CTRL_ADDR, RESP_OKAY);
		chk("err flag", rd[15], 1'b1);
		chk("err irq", irq, 1'b1);
		wr(CTRL_ADDR, 16'h0600, RESP_OKAY);
		rdr(CTRL_ADDR, RESP_OKAY);
		chk("err cleared", rd[15], 1'b0);
		clr_irq();
		// Natural wrap past the top of the count in an index mode
		wr(POS_ADDR, 16'hffff, RESP_OKAY);
		steps(2, 1);
		exp_pos = 1;
		chk_pos();
		chk("no wrap irq", irq, 1'b0);
		wr(FILT_ADDR, 16'h0100, RESP_OKAY);
		wr(POS_ADDR, 16'h0004, RESP_OKAY);
		steps(2, 1);
		rdr(CTRL_ADDR, RESP_OKAY);
		chk("err flag count_error_irq_disable", rd[15], 1'b1);
		chk("irq count_error_irq_disable", irq, 1'b0);
		steps(2, 0);
		wr(CTRL_ADDR, 16'h0500, RESP_OKAY);
		wr(FILT_ADDR, 16'h0000, RESP_OKAY);
		// Max-match mode wraps at max both ways
		wr(MAX_ADDR, 16'h0003, RESP_OKAY);
		wr(POS_ADDR, 16'h0000, RESP_OKAY);
		steps(8, 1);
		exp_pos = 0;
		chk_pos();
		chk("max irq", irq, 1'b1);
		clr_irq();
		chk("irq clear", irq, 1'b0);
		steps(2, 0);
		exp_pos = 3;
		chk_pos();
		steps(2, 1);
		// Filter swallows a two-cycle spike
		wr(CTRL_ADDR, 16'h0600, RESP_OKAY);
		wr(FILT_ADDR, 16'h0080, RESP_OKAY);
		wr(POS_ADDR, 16'h0000, RESP_OKAY);
		qei_enc_model_i.glitch();
		steps(4, 1);
		exp_pos = 4;
		chk_pos();
		wr(CTRL_ADDR, 16'h2600, RESP_OKAY);
		cpu_idle <= 1'b1;
		steps(4, 1);
		chk_pos();
		// Random count survives a trip through timer mode
		seed = lfsr(seed);
		exp_pos = seed[15:0];
		wr(POS_ADDR, seed[15:0], RESP_OKAY);
		wr(CTRL_ADDR, 16'h2100, RESP_OKAY);
		wr(CTRL_ADDR, 16'h2600, RESP_OKAY);
		chk_pos();
		cpu_idle <= 1'b0;
		wr(MAX_ADDR, 16'h0014, RESP_OKAY);
		wr(POS_ADDR, 16'h0000, RESP_OKAY);
		clr_irq();
		wr(CTRL_ADDR, 16'h0900, RESP_OKAY);
		repeat (30) @(posedge aclk);
		chk("timer irq", irq, 1'b1);
		rdr(POS_ADDR, RESP_OKAY);
		chk("timer bound", rd <= 32'h14, 1'b1);
		// x4 with max match wraps on edges of both phases
		wr(CTRL_ADDR, 16'h0700, RESP_OKAY);
		wr(MAX_ADDR, 16'h0003, RESP_OKAY);
		wr(POS_ADDR, 16'h0000, RESP_OKAY);
		steps(5, 1);
		exp_pos = 1;
		chk_pos();
		// Direction from the low phase B pin overrides the written up bit
		wr(POS_ADDR, 16'h0100, RESP_OKAY);
		wr(CTRL_ADDR, 16'h0901, RESP_OKAY);
		rdr(POS_ADDR, RESP_OKAY);
		chk("timer pin dir", rd < 32'h100 && rd > 32'hf0, 1'b1);
		tally_and_finish();
	end
endmodule // test_qei_encoder
